// ### pkg/dcs_pkg.sv
// Purpose: constants and types for the disk control store sequencer
// Assumes: 64 x 32-bit store, four instruction bytes per word
// Notes: byte lanes are error, control, value, count from msb down
package dcs_pkg;
   localparam int DCS_DEPTH = 64;
   localparam int DCS_AW = 6;
   // Instruction byte lanes
   localparam int ERR_LSB = 24;
   localparam int CTL_LSB = 16;
   localparam int VAL_LSB = 8;
   localparam int CNT_LSB = 0;
   // Error byte fields
   localparam int E_SEG_ID_LOAD = 7;
   localparam int E_RS_ENABLE = 6;
   localparam int E_SKIP_MSB = 5;
   localparam int E_SKIP_LSB_EOS = 4;
   localparam int E_FAIL = 3;
   localparam int E_RETRY = 2;
   localparam int E_DATA_ACTIVE = 1;
   localparam int E_USER_OUT = 0;
   // Control byte fields
   localparam int C_VAL_SEL = 7;
   localparam int C_CNT_SEL = 6;
   localparam int C_WRITE_GATE = 5;
   localparam int C_READ_GATE = 4;
   localparam int C_ADDR_MARK = 3;
   localparam int C_COMPARE = 2;
   localparam int C_SKIP_EN = 1;
   localparam int C_LOOP_EN = 0;
   // Value byte fields
   localparam int V_BUF_XFER = 7;
   localparam int V_NO_XFER = 6;
   localparam int V_LAST = 5;
   localparam int V_ID_ROUTE = 4;
   localparam int V_CHECK = 3;
   localparam int V_LRC = 2;
   localparam int V_CRC = 1;
   localparam int V_DEFECT_SKIP = 0;
   // Count byte fields
   localparam int K_WAIT_AM = 6;
   localparam int K_WAIT_IDX = 5;
   localparam int K_WAIT_SM = 4;
   localparam int K_STOP = 3;
   localparam int K_WAIT_GCZ = 0;
   // Reset values and LRC byte count
   localparam logic [5:0] DCS_START_RST = 6'h00;
   localparam logic [1:0] LRC_BYTES = 2'h2;
   typedef enum logic [1:0] {DCS_IDLE, DCS_EXEC, DCS_WAIT} dcs_state_t;
endpackage

// ### hw/dcs_buf2.sv
// Purpose: two-entry valid/ready buffer in the disk data path
// Assumes: single clock, asynchronous active-low reset
// Notes: full throughput; a stalled sink holds both words
`timescale 1ns/1ps
module dcs_buf2
   import dcs_pkg::*;
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_arst_n,
   // Fill side
   input wire logic i_valid,
   input wire logic [7:0] i_data,
   output logic o_ready,
   // Drain side
   output logic o_valid,
   output logic [7:0] o_data,
   input wire logic i_ready
);
   logic [7:0] mem_r [2];
   logic wp_r;
   logic rp_r;
   logic [1:0] cnt_r;
   logic push;
   logic pop;
   assign o_ready = (cnt_r != 2'h2);
   assign o_valid = (cnt_r != 2'h0);
   assign o_data = mem_r[rp_r];
   assign push = i_valid && o_ready;
   assign pop = o_valid && i_ready;
   always_ff @(posedge i_mclk) begin
      if (push) begin
         mem_r[wp_r] <= i_data;
      end
   end
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wp_r <= 1'b0;
         rp_r <= 1'b0;
         cnt_r <= 2'h0;
      end else begin
         if (push) begin
            wp_r <= ~wp_r;
         end
         if (pop) begin
            rp_r <= ~rp_r;
         end
         cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule

// ### hw/dcs_seq.sv
// Purpose: disk writable control store and its sequencer
// Assumes: processor loads store and config before pulsing start
// Notes: mark and index pins are synchronised here; store port is synchronous
`timescale 1ns/1ps
// Function
// RULE1: store of 64 words, 32 bits, four bytes
// RULE2: processor loads store before any start
// RULE3: segment-load rise loads counter, arms segmentation
// RULE4: ECC enabled by RS bit and gate
// RULE5: skip select picks skip address register
// RULE6: end-of-sector updates buffer and block counts
// RULE7: fail bit chooses which errors stop
// RULE8: defect skip on size exhaustion or mark
// RULE9: LRC compares two bytes per sector
// RULE10: CRC enable starts, with check compares
// RULE11: stall until generic counter zero, then branch
// RULE12: loop jump while block count above zero
// RULE13: operand select immediate or other source
// RULE14: control bits drive gates, mark, compare
// RULE15: value bits buffer, block count, last
// RULE16: value bits ID route and check
// RULE17: count bits wait mark, index, sector; stop
// RULE18: retry, data active, user output pin
// RULE19: otherwise advance to next location
module dcs_seq
   import dcs_pkg::*;
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_arst_n,
   // Control store load port
   input wire logic i_cs_we,
   input wire logic [5:0] i_cs_addr,
   input wire logic [31:0] i_cs_wdata,
   output logic [31:0] o_cs_rdata,
   // Configuration
   input wire logic i_start,
   input wire logic [5:0] i_start_addr,
   input wire logic i_segmented_id_mode,
   input wire logic i_lrc_check_config,
   input wire logic [5:0] i_skip_addr1,
   input wire logic [5:0] i_skip_addr2,
   input wire logic [5:0] i_skip_addr3,
   input wire logic [5:0] i_loop_addr,
   input wire logic [9:0] i_id_segment,
   input wire logic [7:0] i_alt_value,
   input wire logic [7:0] i_alt_count,
   input wire logic [7:0] i_block_count,
   input wire logic [9:0] i_defect_size,
   // Disk pins
   input wire logic i_addr_mark,
   input wire logic i_index,
   input wire logic i_sector_mark,
   input wire logic i_segment_type,
   input wire logic i_last_segment,
   input wire logic [7:0] i_disk_data,
   input wire logic i_disk_valid,
   input wire logic i_disk_err,
   input wire logic i_ecc_err,
   // Data path out
   output logic o_data_valid,
   output logic [7:0] o_data,
   input wire logic i_data_ready,
   output logic o_disk_ready,
   // Sequencer outputs
   output logic o_busy,
   output logic [5:0] o_pc,
   output logic o_write_gate,
   output logic o_read_gate,
   output logic o_addr_mark_enable,
   output logic o_compare_enable,
   output logic o_rs_enable,
   output logic o_id_route,
   output logic o_check_send,
   output logic o_crc_calc,
   output logic o_crc_compare,
   output logic o_lrc_mismatch,
   output logic o_retry_enable,
   output logic o_data_active,
   output logic o_user_out,
   output logic o_buf_xfer,
   output logic o_block_dec,
   output logic o_count_update,
   output logic o_fail,
   output logic o_seg_armed,
   output logic [9:0] o_seg_count,
   output logic [7:0] o_value_op,
   output logic [7:0] o_count_op
);
   logic [31:0] store_r [DCS_DEPTH]; // RULE1
   dcs_state_t state_r;
   logic [5:0] pc_r;
   logic [31:0] ins_r;
   logic [2:0] s1_r;
   logic [2:0] s2_r;
   logic seg_prev_r;
   logic [9:0] gen_cnt_r;
   logic [1:0] lrc_cnt_r;
   logic [7:0] lrc_acc_r;
   logic [7:0] e, c, v, k;
   logic am, ix, sm, fin, wait_ok, skip_ok, errs, last_or_stop;
   logic [5:0] pc_nxt, skip_tgt;

   assign e = ins_r[ERR_LSB +: 8];
   assign c = ins_r[CTL_LSB +: 8];
   assign v = ins_r[VAL_LSB +: 8];
   assign k = ins_r[CNT_LSB +: 8];
   assign am = s2_r[0];
   assign ix = s2_r[1];
   assign sm = s2_r[2];

   // Pin strobes pass two flops before any decode
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s1_r <= 3'h0;
         s2_r <= 3'h0;
      end else begin
         s1_r <= {i_sector_mark, i_index, i_addr_mark};
         s2_r <= s1_r;
      end
   end

   // Store loading is only for an idle sequencer
   always_ff @(posedge i_mclk) begin
      if (i_cs_we && state_r == DCS_IDLE) begin
         store_r[i_cs_addr] <= i_cs_wdata; // RULE2
      end
   end
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_cs_rdata <= 32'h0000_0000;
      end else begin
         o_cs_rdata <= store_r[i_cs_addr];
      end
   end

   always_comb begin
      wait_ok = 1'b1;
      if (k[K_WAIT_AM] && !am) wait_ok = 1'b0; // RULE17
      if (k[K_WAIT_IDX] && !ix) wait_ok = 1'b0; // RULE17
      if (k[K_WAIT_SM] && !sm) wait_ok = 1'b0; // RULE17
      if (k[K_WAIT_GCZ] && gen_cnt_r != 10'h000) wait_ok = 1'b0; // RULE11
   end

   // Defect skip gates the skip branch on size exhaustion or sector mark by segment type
   assign skip_ok = !v[V_DEFECT_SKIP] ||
                    (i_segment_type ? sm : (gen_cnt_r == 10'h000)); // RULE8
   // End of sector widens the failure net to ECC errors
   assign errs = i_disk_err || (e[E_SKIP_LSB_EOS] && !c[C_SKIP_EN] && i_ecc_err); // RULE7
   assign fin = (state_r == DCS_EXEC) && wait_ok;
   assign last_or_stop = v[V_LAST] || k[K_STOP] || (e[E_FAIL] && errs); // RULE15 RULE17

   always_comb begin
      unique case (e[E_SKIP_MSB -: 2])
         2'h1: skip_tgt = i_skip_addr1; // RULE5
         2'h2: skip_tgt = i_skip_addr2;
         default: skip_tgt = i_skip_addr3;
      endcase
      pc_nxt = pc_r + 6'h01; // RULE19
      if (c[C_SKIP_EN] && skip_ok && !(k[K_WAIT_GCZ] && i_last_segment)) begin
         pc_nxt = skip_tgt; // RULE5 RULE11
      end else if (c[C_LOOP_EN] && i_block_count != 8'h00) begin
         pc_nxt = i_loop_addr; // RULE12
      end
   end

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_r <= DCS_IDLE;
         pc_r <= DCS_START_RST;
         ins_r <= 32'h0000_0000;
         o_fail <= 1'b0;
      end else begin
         unique case (state_r)
            DCS_IDLE: begin
               if (i_start) begin
                  pc_r <= i_start_addr;
                  state_r <= DCS_WAIT;
                  o_fail <= 1'b0;
               end
            end
            DCS_WAIT: begin
               ins_r <= store_r[pc_r];
               state_r <= DCS_EXEC;
            end
            DCS_EXEC: begin
               if (fin) begin
                  if (last_or_stop) begin
                     state_r <= DCS_IDLE;
                     ins_r <= 32'h0000_0000;
                     o_fail <= e[E_FAIL] && errs; // RULE7
                  end else begin
                     pc_r <= pc_nxt;
                     ins_r <= store_r[pc_nxt];
                  end
               end
            end
         endcase
      end
   end

   // Generic counter and segment arm
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         seg_prev_r <= 1'b0;
         gen_cnt_r <= 10'h000;
         o_seg_armed <= 1'b0;
      end else begin
         seg_prev_r <= e[E_SEG_ID_LOAD];
         if (i_segmented_id_mode && e[E_SEG_ID_LOAD] && !seg_prev_r) begin
            gen_cnt_r <= i_id_segment; // RULE3
            o_seg_armed <= 1'b1; // RULE3
         end else begin
            if (state_r == DCS_IDLE) o_seg_armed <= 1'b0;
            if (gen_cnt_r != 10'h000 && i_disk_valid && o_disk_ready) begin
               gen_cnt_r <= gen_cnt_r - 10'h001;
            end else if (v[V_DEFECT_SKIP] && gen_cnt_r == 10'h000 && !fin) begin
               gen_cnt_r <= i_defect_size;
            end
         end
      end
   end

   // LRC: two bytes per sector against running xor
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         lrc_cnt_r <= 2'h0;
         lrc_acc_r <= 8'h00;
         o_lrc_mismatch <= 1'b0;
      end else if (state_r == DCS_IDLE) begin
         lrc_cnt_r <= 2'h0;
         lrc_acc_r <= 8'h00;
      end else if (i_disk_valid && o_disk_ready) begin
         if (v[V_LRC] && i_lrc_check_config && lrc_cnt_r != LRC_BYTES) begin
            lrc_cnt_r <= lrc_cnt_r + 2'h1; // RULE9
            if (i_disk_data != lrc_acc_r) o_lrc_mismatch <= 1'b1; // RULE9
         end else if (!v[V_LRC]) begin
            lrc_acc_r <= lrc_acc_r ^ i_disk_data;
         end
      end
   end

   // Registered instruction strobes
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_count_update <= 1'b0;
         o_block_dec <= 1'b0;
      end else begin
         o_count_update <= fin && !c[C_SKIP_EN] && e[E_SKIP_LSB_EOS] &&
                           !i_disk_err && gen_cnt_r == 10'h000; // RULE6
         o_block_dec <= fin && v[V_NO_XFER]; // RULE15
      end
   end

   // Field outputs follow the executing instruction
   assign o_busy = (state_r != DCS_IDLE);
   assign o_pc = pc_r;
   assign o_write_gate = c[C_WRITE_GATE]; // RULE14
   assign o_read_gate = c[C_READ_GATE]; // RULE14
   assign o_addr_mark_enable = c[C_ADDR_MARK]; // RULE14
   assign o_compare_enable = c[C_COMPARE]; // RULE14
   assign o_rs_enable = e[E_RS_ENABLE] && (c[C_READ_GATE] || c[C_WRITE_GATE]); // RULE4
   assign o_id_route = v[V_ID_ROUTE]; // RULE16
   assign o_check_send = v[V_CHECK]; // RULE16
   assign o_crc_calc = v[V_CRC] && !v[V_CHECK]; // RULE10
   assign o_crc_compare = v[V_CRC] && v[V_CHECK]; // RULE10
   assign o_retry_enable = e[E_RETRY]; // RULE18
   assign o_data_active = e[E_DATA_ACTIVE]; // RULE18
   assign o_user_out = e[E_USER_OUT]; // RULE18
   assign o_buf_xfer = v[V_BUF_XFER]; // RULE15
   assign o_seg_count = gen_cnt_r;
   assign o_value_op = c[C_VAL_SEL] ? i_alt_value : v; // RULE13
   assign o_count_op = c[C_CNT_SEL] ? i_alt_count : k; // RULE13

   dcs_buf2 u_buf (
      .i_mclk(i_mclk),
      .i_arst_n(i_arst_n),
      .i_valid(i_disk_valid && v[V_BUF_XFER]),
      .i_data(i_disk_data),
      .o_ready(o_disk_ready),
      .o_valid(o_data_valid),
      .o_data(o_data),
      .i_ready(i_data_ready)
   );

   rs_gate_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      o_rs_enable |-> e[E_RS_ENABLE] && (o_read_gate || o_write_gate)) // RULE4
      else $error("ECC enabled without gate");
   seg_load_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (i_segmented_id_mode && e[E_SEG_ID_LOAD] && !seg_prev_r) |=>
      o_seg_armed && gen_cnt_r == $past(i_id_segment)) // RULE3
      else $error("Segment load missed");
   loop_jump_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (fin && !last_or_stop && !c[C_SKIP_EN] && c[C_LOOP_EN] && i_block_count != 8'h00)
      |=> pc_r == $past(i_loop_addr)) // RULE12
      else $error("Loop jump wrong");
   next_loc_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (fin && !last_or_stop && !c[C_SKIP_EN] && !c[C_LOOP_EN])
      |=> pc_r == $past(pc_r) + 6'h01) // RULE19
      else $error("No sequential advance");
   gcz_wait_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (state_r == DCS_EXEC && k[K_WAIT_GCZ] && gen_cnt_r != 10'h000)
      |=> $stable(pc_r) && state_r == DCS_EXEC) // RULE11
      else $error("Counter wait not held");
   mark_wait_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (state_r == DCS_EXEC && k[K_WAIT_SM] && !sm) |=> $stable(pc_r)) // RULE17
      else $error("Sector wait not held");
   stop_idle_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (fin && (k[K_STOP] || v[V_LAST])) |=> state_r == DCS_IDLE) // RULE15 RULE17
      else $error("Stop not honoured");
   crc_excl_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      !(o_crc_calc && o_crc_compare)) // RULE10
      else $error("CRC calc and compare together");
   eos_update_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      o_count_update |-> $past(fin && e[E_SKIP_LSB_EOS] && !c[C_SKIP_EN] && !i_disk_err)) // RULE6
      else $error("Spurious count update");
endmodule

// ### sim/dcs_disk_model.sv
// Purpose: disk drive model, byte stream and index pulse
// Assumes: device samples pins on the rising edge
// Notes: pins change on the falling edge; an unoffered data bus shows inverted bits
`timescale 1ns/1ps
module dcs_disk_model (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_arst_n,
   // Bench control
   input wire logic i_stream_en,
   input wire logic i_index_req,
   // Device handshake
   input wire logic i_ready,
   // Drive pins
   output logic o_valid,
   output logic [7:0] o_data,
   output logic o_index
);
   int seed = 32'h0B8B3D1E;
   logic taken;
   logic en_r;
   logic idx_r;
   int hold;
   initial begin
      o_valid = 1'b0;
      o_data = 8'hA5;
      o_index = 1'b0;
      taken = 1'b0;
      en_r = 1'b0;
      idx_r = 1'b0;
      hold = 0;
   end
   // Bench controls change on the falling edge, so take them on the rising one
   always @(posedge i_mclk) begin
      taken <= o_valid && i_ready;
      en_r <= i_stream_en;
      idx_r <= i_index_req;
   end
   always @(negedge i_mclk) begin
      // A byte stays offered until the device takes it
      if (o_valid && !taken) begin
      end else if (en_r && i_arst_n && $random(seed) % 2 != 0) begin
         o_valid <= 1'b1;
         o_data <= 8'($random(seed));
      end else begin
         o_valid <= 1'b0;
         o_data <= ~o_data;
      end
      // Index held several cycles so the two-flop synchroniser sees it
      hold = idx_r ? 4 : (hold > 0 ? hold - 1 : 0);
      o_index <= hold > 0;
   end
endmodule

// ### sim/tb_top.sv
// Purpose: self-checking bench for the disk control store sequencer
// Assumes: inputs driven on the falling edge
// Notes: pc trace and buffer bytes are checked against queued notes
`timescale 1ns/1ps
module tb_top;
   import dcs_pkg::*;
   logic i_mclk, i_arst_n, i_cs_we, i_start, i_data_ready, i_disk_err, stream_en, index_req;
   logic disk_valid, disk_index, o_data_valid, o_disk_ready, o_busy, o_fail, o_upd, o_dec;
   logic [5:0] i_cs_addr, i_start_addr, o_pc, last_pc, sk1, sk2, sk3, lp;
   logic [31:0] i_cs_wdata, o_cs_rdata;
   logic [63:0] cfg;
   logic [7:0] i_block_count, disk_data, o_data, o_value_op, o_count_op;
   logic [8:0] fl;
   logic [3:0] fx;
   logic [9:0] o_seg_count;
   logic o_seg_armed;
   logic [31:0] mem [64];
   logic [5:0] pc_q[$];
   logic [7:0] d_q[$];
   int seed = 32'h0B8B3D1D;
   int bad_count = 0, total_checks = 0, cycles = 0, n_upd = 0, n_dec = 0;

   dcs_seq dcs_seq_i (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_cs_we(i_cs_we),
      .i_cs_addr(i_cs_addr), .i_cs_wdata(i_cs_wdata), .o_cs_rdata(o_cs_rdata),
      .i_start(i_start), .i_start_addr(i_start_addr), .i_segmented_id_mode(cfg[0]),
      .i_lrc_check_config(cfg[1]), .i_skip_addr1(sk1), .i_skip_addr2(sk2),
      .i_skip_addr3(sk3), .i_loop_addr(lp), .i_id_segment(cfg[11:2]),
      .i_alt_value(cfg[19:12]), .i_alt_count(cfg[27:20]), .i_block_count(i_block_count),
      .i_defect_size(cfg[37:28]), .i_addr_mark(disk_index), .i_index(disk_index),
      .i_sector_mark(disk_index), .i_segment_type(cfg[38]), .i_last_segment(cfg[39]),
      .i_disk_data(disk_data), .i_disk_valid(disk_valid), .i_disk_err(i_disk_err),
      .i_ecc_err(i_disk_err), .o_data_valid(o_data_valid), .o_data(o_data),
      .i_data_ready(i_data_ready), .o_disk_ready(o_disk_ready), .o_busy(o_busy),
      .o_pc(o_pc), .o_write_gate(fl[8]), .o_read_gate(fl[7]), .o_addr_mark_enable(fl[6]),
      .o_compare_enable(fl[5]), .o_rs_enable(fl[4]), .o_id_route(fx[3]), .o_check_send(fx[2]),
      .o_crc_calc(fx[1]), .o_crc_compare(fx[0]), .o_lrc_mismatch(), .o_retry_enable(fl[3]),
      .o_data_active(fl[2]), .o_user_out(fl[1]), .o_buf_xfer(fl[0]), .o_block_dec(o_dec),
      .o_count_update(o_upd), .o_fail(o_fail), .o_seg_armed(o_seg_armed),
      .o_seg_count(o_seg_count),
      .o_value_op(o_value_op), .o_count_op(o_count_op));

   dcs_disk_model dcs_disk_model_i (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
      .i_stream_en(stream_en), .i_index_req(index_req), .i_ready(o_disk_ready),
      .o_valid(disk_valid), .o_data(disk_data), .o_index(disk_index));

   initial begin
      i_mclk = 1'b0;
      forever #25 i_mclk = ~i_mclk;
   end

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_word(input logic [31:0] g, input logic [31:0] e); cmp(g, e); endtask
   task automatic cmp_pc(input logic [5:0] g, input logic [5:0] e); cmp(32'(g), 32'(e)); endtask
   task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e); cmp(32'(g), 32'(e)); endtask
   task automatic cmp_flags(input logic [15:0] g, input logic [15:0] e); cmp(32'(g), 32'(e)); endtask

   task automatic end_of_test;
      $display("checks=%0d mismatches=%0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic ld(input logic [5:0] a, input logic [31:0] w);
      @(negedge i_mclk);
      i_cs_we = 1'b1;
      i_cs_addr = a;
      i_cs_wdata = w;
      @(negedge i_mclk);
      i_cs_we = 1'b0;
   endtask

   task automatic kick(input logic [5:0] a);
      @(negedge i_mclk);
      cfg = {$random(seed), $random(seed)};
      i_start_addr = a;
      i_start = 1'b1;
      @(negedge i_mclk);
      i_start = 1'b0;
   endtask

   task automatic wait_idle;
      for (int i = 0; i < 300 && o_busy !== 1'b0; i++) @(negedge i_mclk);
      repeat (3) @(negedge i_mclk);
      cmp_flags(16'(o_busy), 16'h0);
      cmp_flags(16'(pc_q.size()), 16'h0);
   endtask

   // Stall on index, check decoded fields, optionally stream into the buffer
   // Address mark, index and sector mark all follow the one drive pulse
   task automatic stall_prog(input logic [31:0] w, input logic [8:0] ef, input logic [3:0] xf,
                             input bit vsel);
      ld(6'h32, w);
      pc_q.push_back(6'h32);
      kick(6'h32);
      repeat (4) @(negedge i_mclk);
      cmp_flags(16'(fl), 16'(ef));
      cmp_flags(16'(fx), 16'(xf));
      cmp_flags({o_value_op, o_count_op}, vsel ? {cfg[19:12], cfg[27:20]} : w[15:0]);
      stream_en = 1'b1;
      repeat (60) begin
         @(negedge i_mclk);
         i_data_ready = 1'($random(seed));
      end
      stream_en = 1'b0;
      i_data_ready = 1'b1;
      repeat (6) @(negedge i_mclk);
      cmp_pc(o_pc, 6'h32);
      index_req = 1'b1;
      @(negedge i_mclk);
      index_req = 1'b0;
      wait_idle();
   endtask

   always @(posedge i_mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         end_of_test();
      end
      if (i_arst_n) begin
         if (o_busy && o_pc !== last_pc) begin
            if (pc_q.size() > 0) cmp_pc(o_pc, pc_q.pop_front());
            else cmp_pc(o_pc, ~o_pc);
         end
         last_pc <= o_busy ? o_pc : 6'bx;
         if (disk_valid && o_disk_ready && fl[0]) d_q.push_back(disk_data);
         if (o_data_valid && i_data_ready) begin
            if (d_q.size() > 0) cmp_byte(o_data, d_q.pop_front());
            else cmp_byte(o_data, ~o_data);
         end
         n_upd <= n_upd + 32'(o_upd);
         n_dec <= n_dec + 32'(o_dec);
      end
   end

   initial begin
      {i_cs_we, i_start, stream_en, index_req, i_disk_err} = 5'h00;
      {i_data_ready, i_arst_n, last_pc} = {2'b10, 6'bx};
      {i_cs_addr, i_start_addr, i_cs_wdata, cfg, i_block_count} = '0;
      {sk1, sk2, sk3, lp} = {6'h28, 6'h29, 6'h2A, 6'h14};
      repeat (20) @(negedge i_mclk);
      i_arst_n = 1'b1;
      // Store holds 64 independent words
      for (int i = 0; i < 64; i++) begin
         mem[i] = $random(seed);
         ld(6'(i), mem[i]);
      end
      for (int i = 0; i < 64; i++) begin
         i_cs_addr = 6'(i);
         @(negedge i_mclk);
         cmp_word(o_cs_rdata, mem[i]);
      end
      ld(6'h0A, 32'h0001_0000);
      ld(6'h14, 32'h0000_2000);
      ld(6'h0B, 32'h0000_2000);
      // Loop jump taken while the block count is above zero, else fall through
      for (int b = 0; b < 2; b++) begin
         i_block_count = b == 0 ? 8'h05 : 8'h00;
         pc_q.push_back(6'h0A);
         pc_q.push_back(b == 0 ? 6'h14 : 6'h0B);
         kick(6'h0A);
         wait_idle();
      end
      // Skip select values 1 to 3 each pick their skip register
      for (int s = 1; s < 4; s++) begin
         ld(6'h1E, {2'b00, 2'(s), 4'h0, 24'h020000});
         ld(6'(39 + s), 32'h0000_2000);
         pc_q.push_back(6'h1E);
         pc_q.push_back(6'(39 + s));
         kick(6'h1E);
         wait_idle();
      end
      // End of sector with and without a disk error
      ld(6'h3C, 32'h1800_6000);
      for (int e = 0; e < 2; e++) begin
         i_disk_err = 1'(e);
         n_upd = 0;
         n_dec = 0;
         pc_q.push_back(6'h3C);
         kick(6'h3C);
         wait_idle();
         cmp_flags({4'(n_upd), 4'(n_dec), 7'h0, o_fail}, {4'(1 - e), 4'h1, 7'h0, 1'(e)});
      end
      i_disk_err = 1'b0;
      stall_prog(32'h473C_A020, 9'h1FF, 4'h0, 1'b0);
      stall_prog(32'h40C0_2050, 9'h000, 4'h0, 1'b1);
      stall_prog(32'h0000_3A20, 9'h000, 4'hD, 1'b0);
      stall_prog(32'h0000_2220, 9'h000, 4'h2, 1'b0);
      // Segment bit rise loads the counter; the next word waits for it to drain
      ld(6'h33, 32'h8000_0020);
      ld(6'h34, 32'h0000_2001);
      pc_q.push_back(6'h33);
      pc_q.push_back(6'h34);
      kick(6'h33);
      cfg[11:0] = {10'h008, cfg[1], 1'b1};
      repeat (3) @(negedge i_mclk);
      cmp_flags({5'h0, o_seg_armed, o_seg_count}, 16'h0408);
      index_req = 1'b1;
      @(negedge i_mclk);
      index_req = 1'b0;
      repeat (8) @(negedge i_mclk);
      cmp_pc(o_pc, 6'h34);
      stream_en = 1'b1;
      wait_idle();
      stream_en = 1'b0;
      cmp_flags(16'(o_seg_count), 16'h0);
      cmp_flags(16'(d_q.size()), 16'h0);
      end_of_test();
   end
endmodule
